// *** common/fpc_defs.svh ***
/*
 Register offsets, field positions and reset values of the fine pulse capture unit.
 Assumes a 16-bit word address bus; offsets are word indices as printed.
*/
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

`define FPC_ADDR_W        16
`define FPC_DATA_W        16
`define FPC_OFF_CTRL      16'h6ac0
`define FPC_OFF_FLAGS     16'h6ac1
`define FPC_OFF_CLEAR     16'h6ac2
`define FPC_OFF_FORCE     16'h6ac3
`define FPC_OFF_COUNTER   16'h6ac4
`define FPC_OFF_RISE0     16'h6ad0
`define FPC_OFF_FALL0     16'h6ad2
`define FPC_OFF_RISE1     16'h6ad8
`define FPC_OFF_FALL1     16'h6ada
`define FPC_OFF_MASK      16'h6ac5

// Control field positions
`define FPC_CTL_ENABLE    0
`define FPC_CTL_HIRES     1
`define FPC_CTL_DELTA     2
`define FPC_CTL_CLKSEL    3
`define FPC_CTL_CAL       4
`define FPC_CTL_RISEIE    5
`define FPC_CTL_FALLIE    6

// Flag field positions
`define FPC_FLG_INT       0
`define FPC_FLG_RISE      1
`define FPC_FLG_FALL      2
`define FPC_FLG_OVF       3
`define FPC_FLG_MASK      16'h000f

`define FPC_CTRL_RST      16'h0000
`define FPC_ZERO16        16'h0000
`define FPC_ONE16         16'h0001
`define FPC_FINE_W        4
`define FPC_FINE_ZERO     4'h0

`endif

// *** common/fpc_pkg.sv ***
/*
 Types of the fine pulse capture unit.
 Assumes fpc_defs.svh for widths.
*/
`include "fpc_defs.svh"

package fpc_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [`FPC_ADDR_W-1:0] addr;
		logic [`FPC_DATA_W-1:0] wdata;
	} fpc_bus_s;

	typedef struct packed {
		logic rise;
		logic fall;
	} fpc_edge_s;

	typedef enum logic [1:0] {
		FPC_ENTRY0 = 2'b01,
		FPC_ENTRY1 = 2'b10
	} fpc_entry_e;

endpackage : fpc_pkg

// *** rtl/fpc_capture.sv ***
/*
 Fine pulse capture unit: one input pin, 16-bit counter, two-deep rise/fall capture buffer,
 delta mode, fine edge timing, flag/clear/force/mask registers and one level interrupt.
 Assumes inputs synchronous to mclk; fine time code comes from an external delay-line tap.
*/
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "fpc_defs.svh"

// Function
// RULE_01: One capture channel plus calibration path, all serving one dedicated input pin.
// RULE_02: In calibration the capture input comes from the PWM8 fine channel, not the pin.
// RULE_03: Counter ticks on the secondary PLL tick or on the peripheral clock.
// RULE_04: Normal or fine mode; fine mode appends delay-line timing to each capture.
// RULE_05: Delta mode stores intervals between edges instead of absolute counts.
// RULE_06: Rise and fall edges set their own flags and may each interrupt.
// RULE_07: Continuous capture into two entries of rise and fall counts.
// RULE_08: Flag register readable; clear writes reset flags, force writes set them.
// RULE_09: Running counter value readable through its own register.
// RULE_10: Control writes accepted only while write protection is unlocked.
// RULE_11: Software reads captures and clears flags within one pulse width.
// RULE_12: Software recalibrates fine step size while running in fine mode.
// RULE_13: Each edge stores counter into current entry, entry alternates after fall.
module fpc_capture #(
	parameter int CNT_W  = 16,
	parameter int FINE_W = `FPC_FINE_W
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	// Register port
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [`FPC_ADDR_W-1:0] reg_addr,
	input  wire logic [`FPC_DATA_W-1:0] reg_wdata,
	output logic      [`FPC_DATA_W-1:0] reg_rdata,
	// System
	input  wire logic                   write_protect_unlock,
	input  wire logic                   secondary_pll_tick,
	// Capture sources
	input  wire logic                   capture_pin,
	input  wire logic                   pwm_module8_channel_a,
	input  wire logic [FINE_W-1:0]      fine_edge_code,
	// Status
	output logic                        cal_active,
	output logic                        irq
);

	logic [`FPC_DATA_W-1:0] ctrl_r;
	logic [`FPC_DATA_W-1:0] flags_r;
	logic [`FPC_DATA_W-1:0] flags_nxt;
	logic [`FPC_DATA_W-1:0] mask_r;
	logic [CNT_W-1:0]       cnt_r;
	logic [CNT_W-1:0]       cnt_nxt;
	logic [CNT_W-1:0]       last_r;
	logic [`FPC_DATA_W-1:0] rise_r [2];
	logic [`FPC_DATA_W-1:0] fall_r [2];
	logic                   in_r;
	logic                   cap_in;
	logic                   tick;
	logic                   rd_flags;
	fpc_pkg::fpc_bus_s      bus;
	fpc_pkg::fpc_edge_s     edg;
	fpc_pkg::fpc_entry_e    entry_r;

	function automatic logic hit(input logic [`FPC_ADDR_W-1:0] a, input logic [`FPC_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
	assign cal_active = ctrl_r[`FPC_CTL_CAL];

	// Calibration steers the PWM fine channel in place of the pin
	assign cap_in = cal_active ? pwm_module8_channel_a : capture_pin; // RULE_02 RULE_01

	assign tick = ctrl_r[`FPC_CTL_CLKSEL] ? secondary_pll_tick : 1'b1; // RULE_03

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			in_r <= 1'b0;
		else
			in_r <= cap_in;
	end

	assign edg.rise = ctrl_r[`FPC_CTL_ENABLE] & cap_in & ~in_r; // RULE_06
	assign edg.fall = ctrl_r[`FPC_CTL_ENABLE] & ~cap_in & in_r; // RULE_06

	// Protected control register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= `FPC_CTRL_RST;
		else if (bus.wr && hit(bus.addr, `FPC_OFF_CTRL) && write_protect_unlock) // RULE_10
			ctrl_r <= bus.wdata;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mask_r <= `FPC_ZERO16;
		else if (bus.wr && hit(bus.addr, `FPC_OFF_MASK))
			mask_r <= bus.wdata & `FPC_FLG_MASK;
	end

	// Free-running counter; wrap raises the overflow flag
	assign cnt_nxt = cnt_r + CNT_W'(1);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else if (ctrl_r[`FPC_CTL_ENABLE] && tick)
			cnt_r <= cnt_nxt; // RULE_03
	end

	function automatic logic [`FPC_DATA_W-1:0] cap_val(input logic [CNT_W-1:0] c,
		input logic [CNT_W-1:0] l, input logic [FINE_W-1:0] f, input logic [`FPC_DATA_W-1:0] ctl);
		logic [CNT_W-1:0] v;
		v = ctl[`FPC_CTL_DELTA] ? c - l : c; // RULE_05
		cap_val = ctl[`FPC_CTL_HIRES] ? {v[`FPC_DATA_W-FINE_W-1:0], f} : v; // RULE_04
	endfunction : cap_val

	// Two-deep buffer fill and entry alternation
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rise_r[0] <= `FPC_ZERO16;
			rise_r[1] <= `FPC_ZERO16;
			fall_r[0] <= `FPC_ZERO16;
			fall_r[1] <= `FPC_ZERO16;
			last_r    <= '0;
			entry_r   <= fpc_pkg::FPC_ENTRY0;
		end
		else
		begin
			if (edg.rise || edg.fall)
				last_r <= cnt_r; // RULE_05
			if (edg.rise)
			begin
				case (entry_r)
					fpc_pkg::FPC_ENTRY0: rise_r[0] <= cap_val(cnt_r, last_r, fine_edge_code, ctrl_r); // RULE_13 RULE_07
					fpc_pkg::FPC_ENTRY1: rise_r[1] <= cap_val(cnt_r, last_r, fine_edge_code, ctrl_r); // RULE_13 RULE_07
					default: rise_r[0] <= cap_val(cnt_r, last_r, fine_edge_code, ctrl_r);
				endcase
			end
			if (edg.fall)
			begin
				case (entry_r)
					fpc_pkg::FPC_ENTRY0:
					begin
						fall_r[0] <= cap_val(cnt_r, last_r, fine_edge_code, ctrl_r); // RULE_13
						entry_r   <= fpc_pkg::FPC_ENTRY1; // RULE_13
					end
					fpc_pkg::FPC_ENTRY1:
					begin
						fall_r[1] <= cap_val(cnt_r, last_r, fine_edge_code, ctrl_r); // RULE_13
						entry_r   <= fpc_pkg::FPC_ENTRY0; // RULE_13
					end
					default: entry_r <= fpc_pkg::FPC_ENTRY0;
				endcase
			end
		end
	end

	// Flags: set wins over clear; flag register read also clears
	assign rd_flags = bus.rd && hit(bus.addr, `FPC_OFF_FLAGS);

	always_comb
	begin
		flags_nxt = flags_r;
		if (rd_flags)
			flags_nxt = `FPC_ZERO16;
		if (bus.wr && hit(bus.addr, `FPC_OFF_CLEAR))
			flags_nxt = flags_nxt & ~bus.wdata; // RULE_08
		if (bus.wr && hit(bus.addr, `FPC_OFF_FORCE))
			flags_nxt = flags_nxt | (bus.wdata & `FPC_FLG_MASK); // RULE_08
		if (edg.rise)
			flags_nxt[`FPC_FLG_RISE] = 1'b1; // RULE_06
		if (edg.fall)
			flags_nxt[`FPC_FLG_FALL] = 1'b1; // RULE_06
		if (ctrl_r[`FPC_CTL_ENABLE] && tick && (cnt_nxt == '0))
			flags_nxt[`FPC_FLG_OVF] = 1'b1;
		flags_nxt[`FPC_FLG_INT] = (flags_nxt[`FPC_FLG_RISE] & ctrl_r[`FPC_CTL_RISEIE])
			| (flags_nxt[`FPC_FLG_FALL] & ctrl_r[`FPC_CTL_FALLIE])
			| (flags_nxt[`FPC_FLG_INT] & ~(rd_flags | (bus.wr && hit(bus.addr, `FPC_OFF_CLEAR)
				&& bus.wdata[`FPC_FLG_INT])));
		flags_nxt = flags_nxt & `FPC_FLG_MASK;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			flags_r <= `FPC_ZERO16;
		else
			flags_r <= flags_nxt;
	end

	assign irq = |(flags_r & mask_r);

	// Read data, one cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= `FPC_ZERO16;
		else if (!bus.rd)
			reg_rdata <= `FPC_ZERO16;
		else
		begin
			case (bus.addr)
				`FPC_OFF_CTRL:    reg_rdata <= ctrl_r;
				`FPC_OFF_FLAGS:   reg_rdata <= flags_r; // RULE_08
				`FPC_OFF_MASK:    reg_rdata <= mask_r;
				`FPC_OFF_COUNTER: reg_rdata <= `FPC_DATA_W'(cnt_r); // RULE_09
				`FPC_OFF_RISE0:   reg_rdata <= rise_r[0]; // RULE_07
				`FPC_OFF_FALL0:   reg_rdata <= fall_r[0];
				`FPC_OFF_RISE1:   reg_rdata <= rise_r[1];
				`FPC_OFF_FALL1:   reg_rdata <= fall_r[1];
				default:          reg_rdata <= `FPC_ZERO16;
			endcase
		end
	end

	a_ctrl_locked: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
		(reg_wr && hit(reg_addr, `FPC_OFF_CTRL) && !write_protect_unlock) |=> $stable(ctrl_r)) // RULE_10
		else $error("control changed while locked");

	a_rise_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
		edg.rise |=> flags_r[`FPC_FLG_RISE]) // RULE_06
		else $error("rise edge did not set flag");

	a_fall_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
		edg.fall |=> flags_r[`FPC_FLG_FALL]) // RULE_06
		else $error("fall edge did not set flag");

	a_force_sets: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
		(reg_wr && hit(reg_addr, `FPC_OFF_FORCE) && reg_wdata[`FPC_FLG_RISE]) |=> flags_r[`FPC_FLG_RISE]) // RULE_08
		else $error("force did not set flag");

	a_clear_works: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
		(reg_wr && hit(reg_addr, `FPC_OFF_CLEAR) && reg_wdata[`FPC_FLG_FALL] && !edg.fall)
		|=> !flags_r[`FPC_FLG_FALL]) // RULE_08
		else $error("clear did not reset flag");

	a_entry_toggle: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_13
		edg.fall |=> entry_r != $past(entry_r)) // RULE_13
		else $error("entry did not alternate");

	a_counter_read: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
		(reg_rd && hit(reg_addr, `FPC_OFF_COUNTER)) |=> reg_rdata == `FPC_DATA_W'($past(cnt_r))) // RULE_09
		else $error("counter read mismatch");

	a_sync_count: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
		(ctrl_r[`FPC_CTL_ENABLE] && !ctrl_r[`FPC_CTL_CLKSEL]) |=> cnt_r == $past(cnt_r) + CNT_W'(1)) // RULE_03
		else $error("counter did not step");

	a_cal_route: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
		cal_active |-> cap_in == pwm_module8_channel_a) // RULE_02
		else $error("calibration input not routed");

	// Capture steps: which edge, which entry, which value form
	sequence s_rise_e0;
		edg.rise && (entry_r == fpc_pkg::FPC_ENTRY0);
	endsequence

	sequence s_rise_e1;
		edg.rise && (entry_r == fpc_pkg::FPC_ENTRY1);
	endsequence

	sequence s_fall_e0;
		edg.fall && (entry_r == fpc_pkg::FPC_ENTRY0);
	endsequence

	sequence s_fall_e1;
		edg.fall && (entry_r == fpc_pkg::FPC_ENTRY1);
	endsequence

	sequence s_plain;
		!ctrl_r[`FPC_CTL_HIRES] && !ctrl_r[`FPC_CTL_DELTA];
	endsequence

	sequence s_flags_read;
		reg_rd && hit(reg_addr, `FPC_OFF_FLAGS) && !edg.rise && !edg.fall;
	endsequence

	sequence s_ctrl_open;
		reg_wr && hit(reg_addr, `FPC_OFF_CTRL) && write_protect_unlock;
	endsequence

	a_rise_store0: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_13
		(s_rise_e0 ##0 s_plain) |=> rise_r[0] == $past(cnt_r))
		else $error("rise count not stored in entry 0");

	a_rise_store1: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
		(s_rise_e1 ##0 s_plain) |=> rise_r[1] == $past(cnt_r))
		else $error("rise count not stored in entry 1");

	a_fall_store0: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
		(s_fall_e0 ##0 s_plain) |=> fall_r[0] == $past(cnt_r))
		else $error("fall count not stored in entry 0");

	a_fall_store1: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_13
		(s_fall_e1 ##0 s_plain) |=> (fall_r[1] == $past(cnt_r)) && (entry_r == fpc_pkg::FPC_ENTRY0))
		else $error("fall count not stored in entry 1");

	a_delta_value: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_05
		(s_fall_e0 ##0 (ctrl_r[`FPC_CTL_DELTA] && !ctrl_r[`FPC_CTL_HIRES])) |=> fall_r[0] == $past(cnt_r - last_r))
		else $error("delta capture wrong");

	a_fine_code: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
		(s_rise_e0 ##0 ctrl_r[`FPC_CTL_HIRES]) |=> rise_r[0][FINE_W-1:0] == $past(fine_edge_code))
		else $error("fine code not appended");

	a_read_clears: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
		s_flags_read |=> !flags_r[`FPC_FLG_RISE] && !flags_r[`FPC_FLG_FALL])
		else $error("flag read did not clear");

	a_int_rise: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
		(edg.rise && ctrl_r[`FPC_CTL_RISEIE]) |=> flags_r[`FPC_FLG_INT])
		else $error("rise interrupt not raised");

	a_int_fall: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
		(edg.fall && ctrl_r[`FPC_CTL_FALLIE]) |=> flags_r[`FPC_FLG_INT])
		else $error("fall interrupt not raised");

	a_mask_write: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
		(reg_wr && hit(reg_addr, `FPC_OFF_MASK)) |=> mask_r == $past(reg_wdata & `FPC_FLG_MASK))
		else $error("mask write lost");

	a_ctrl_open: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
		s_ctrl_open |=> ctrl_r == $past(reg_wdata))
		else $error("unlocked control write lost");

	a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
		!reg_rd |=> reg_rdata == `FPC_ZERO16)
		else $error("read data not idle");

	a_flags_read: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
		(reg_rd && hit(reg_addr, `FPC_OFF_FLAGS)) |=> reg_rdata == $past(flags_r))
		else $error("flag read mismatch");

	a_tick_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
		(ctrl_r[`FPC_CTL_ENABLE] && ctrl_r[`FPC_CTL_CLKSEL] && !secondary_pll_tick) |=> $stable(cnt_r))
		else $error("counter stepped without tick");

	a_idle_count: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
		!ctrl_r[`FPC_CTL_ENABLE] |=> $stable(cnt_r))
		else $error("counter ran while disabled");

	a_pin_route: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
		!cal_active |-> cap_in == capture_pin)
		else $error("pin not routed");

endmodule : fpc_capture

// *** verif/fpc_pulse_src.sv ***
/*
 Pulse source model that drives one capture input.
 Assumes the bench calls pulse() from a single process.
*/
`timescale 1ns/1ps
module fpc_pulse_src (
	// Clock
	input wire logic mclk,
	// Driven input
	output logic     pin
);
	initial pin = 1'b0;

	// Each level lasts whole mclk cycles, changed just after an edge
	task automatic pulse(input int hi, input int lo);
		@(posedge mclk);
		pin <= 1'b1;
		repeat (hi) @(posedge mclk);
		pin <= 1'b0;
		repeat (lo) @(posedge mclk);
	endtask : pulse
endmodule : fpc_pulse_src

// *** verif/tb.sv ***
/*
 Self-checking bench of the fine pulse capture unit.
 Assumes the register offsets and field positions of fpc_defs.svh.
*/
`timescale 1ns/1ps
`include "fpc_defs.svh"
module tb;
	logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        unlock = 1'b0, tick = 1'b0, pin, pwm, cal_active, irq;
	logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, v, a, b, w;
	logic [3:0]  code = 4'h0;
	logic [31:0] seed = 32'h1eab;
	logic [15:0] ent = 16'h0000;
	int          n_errors = 0;
	int          n_checks = 0;

	always #2 mclk = ~mclk;

	fpc_pulse_src src (.mclk(mclk), .pin(pin));
	fpc_pulse_src srcp (.mclk(mclk), .pin(pwm));
	fpc_capture DUT (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .write_protect_unlock(unlock),
		.secondary_pll_tick(tick), .capture_pin(pin), .pwm_module8_channel_a(pwm),
		.fine_edge_code(code), .cal_active(cal_active), .irq(irq));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic print_verdict;
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : check

	task automatic wr(input logic [15:0] ad, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] ad, output logic [15:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// One random pulse, then both captures of the current entry and the flags
	task automatic pulse_cap(input logic [15:0] ctl);
		seed = lfsr(seed);
		w = {13'h0000, seed[2:0]} + 16'h0002;
		code <= seed[7:4];
		wr(`FPC_OFF_CTRL, ctl);
		src.pulse(w, 3);
		rd(`FPC_OFF_RISE0 + ent, a);
		rd(`FPC_OFF_FALL0 + ent, b);
		rd(`FPC_OFF_FLAGS, v);
		ent ^= 16'h0008;
	endtask : pulse_cap

	task automatic counter_step(input logic [15:0] exp);
		rd(`FPC_OFF_COUNTER, a);
		rd(`FPC_OFF_COUNTER, b);
		check(b - a, exp, "counter step");
	endtask : counter_step

	initial
	begin
		repeat (50000) @(posedge mclk);
		n_errors++;
		print_verdict();
	end

	initial
	begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		check({14'h0000, irq, cal_active} | reg_rdata, 16'h0000, "reset outputs");
		wr(`FPC_OFF_CTRL, 16'h0001);
		rd(`FPC_OFF_CTRL, v);
		check(v, `FPC_CTRL_RST, "locked control write");
		counter_step(16'h0000);
		unlock <= 1'b1;
		wr(`FPC_OFF_CTRL, 16'h0001);
		counter_step(16'h0002);
		wr(`FPC_OFF_CTRL, 16'h0009);
		counter_step(16'h0000);
		tick <= 1'b1;
		counter_step(16'h0002);
		for (int i = 0; i < 6; i++)
		begin
			pulse_cap(16'h0001);
			check(b - a, w, "pulse width");
			check(v & 16'h0006, 16'h0006, "edge flags");
		end
		pulse_cap(16'h0005);
		check(b, w, "delta width");
		pulse_cap(16'h0003);
		check(b - a, w << 4, "fine width");
		check({12'h000, b[3:0]}, {12'h000, code}, "fine code");
		wr(`FPC_OFF_MASK, 16'h0002);
		wr(`FPC_OFF_FORCE, 16'h0002);
		@(posedge mclk);
		#1 check({15'h0000, irq}, 16'h0001, "forced irq");
		wr(`FPC_OFF_CLEAR, 16'h0002);
		@(posedge mclk);
		#1 check({15'h0000, irq}, 16'h0000, "cleared irq");
		wr(`FPC_OFF_FORCE, 16'h0004);
		rd(`FPC_OFF_FLAGS, v);
		check((v & 16'h000e) | {15'h0000, irq}, 16'h0004, "masked force");
		rd(`FPC_OFF_FLAGS, v);
		check(v, 16'h0000, "read clears");
		rd(16'h6acf, v);
		check(v, 16'h0000, "unmapped read");
		wr(`FPC_OFF_CTRL, 16'h0021);
		wr(`FPC_OFF_MASK, 16'h0001);
		src.pulse(3, 3);
		check({15'h0000, irq}, 16'h0001, "edge irq");
		wr(`FPC_OFF_CTRL, 16'h0011);
		rd(`FPC_OFF_FLAGS, v);
		check({15'h0000, irq | ~cal_active}, 16'h0000, "calibration entry");
		src.pulse(3, 3);
		rd(`FPC_OFF_FLAGS, v);
		check(v & 16'h0006, 16'h0000, "pin ignored");
		srcp.pulse(3, 3);
		rd(`FPC_OFF_FLAGS, v);
		check(v & 16'h0006, 16'h0006, "calibration edges");
		print_verdict();
	end
endmodule : tb
